// ### hdl/atx_top.sv
// transmit path control: adc arbitration, bias, accessory detect, routing
`timescale 1ns/1ps
`include "atx_consts.svh"
`default_nettype none

module atx_top #(
   parameter int DEBOUNCE_CYCLES   = `ATX_CLK_HZ / `ATX_MS_PER_S * `ATX_DEBOUNCE_MS,
   parameter int LONG_PUSH_CYCLES  = `ATX_CLK_HZ * `ATX_LONG_PUSH_S
) (
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   input  wire logic [`ATX_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`ATX_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     acc_present_raw,
   input  wire logic                     acc_low_imp_raw,
   input  wire logic                     first_pdm_mic,
   input  wire logic                     second_pdm_mic,
   output logic                          host_interrupt_pin,
   output logic                          first_bias_output,
   output logic                          second_bias_output,
   output logic                          first_bias_high,
   output logic                          adc_voice_mode,
   output logic                          adc_stereo_mode,
   output logic                          left_mic_amp_enable,
   output logic                          right_mic_amp_enable,
   output logic                          left_source_select,
   output logic                          right_source_select,
   output atx_pkg::atx_src_t             left_channel_src,
   output atx_pkg::atx_src_t             right_channel_src,
   output logic                          pdm_left_data,
   output logic                          pdm_right_data,
   output logic [1:0]                    left_coarse_gain,
   output logic [1:0]                    right_coarse_gain,
   output logic                          left_input_mute,
   output logic                          right_input_mute,
   output logic [4:0]                    adc_transmit_gain,
   output logic [5:0]                    left_fine_volume,
   output logic [5:0]                    right_fine_volume,
   output logic                          mic_clock_output
);

   localparam int DBW   = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int LPW   = $clog2(LONG_PUSH_CYCLES + 1);
   localparam int HALF_LO = `ATX_CLK_HZ / (2 * `ATX_MCLK_LO_HZ);
   localparam int HALF_HI = `ATX_CLK_HZ / (2 * `ATX_MCLK_HI_HZ);
   localparam int MCW   = $clog2(HALF_LO + 1);

   // ---------------- registers ----------------
   logic [`ATX_CTRL_W-1:0] ctrl;
   logic [`ATX_GAIN_W-1:0] gain;
   logic [`ATX_FLAG_W-1:0] flags;
   logic [`ATX_FLAG_W-1:0] mask;

   // ---------------- bus slave ----------------
   logic [`ATX_ADDR_W-1:0] aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;

   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire ar_take  = s_axi_arvalid & s_axi_arready;

   wire wr_ctrl  = do_write & (aw_addr == `ATX_OFF_CTRL);
   wire wr_gain  = do_write & (aw_addr == `ATX_OFF_GAIN);
   wire wr_flags = do_write & (aw_addr == `ATX_OFF_FLAGS);
   wire wr_mask  = do_write & (aw_addr == `ATX_OFF_MASK);
   wire wr_known = wr_ctrl | wr_gain | wr_flags | wr_mask | (aw_addr == `ATX_OFF_STATUS);

   wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] ctrl_wide = {17'h00000, ctrl};
   wire [31:0] gain_wide = {9'h000, gain};
   wire [31:0] mask_wide = {28'h0000000, mask};
   wire [31:0] ctrl_new  = (ctrl_wide & ~strb_mask) | (w_data & strb_mask);
   wire [31:0] gain_new  = (gain_wide & ~strb_mask) | (w_data & strb_mask);
   wire [31:0] mask_new  = (mask_wide & ~strb_mask) | (w_data & strb_mask);
   wire [`ATX_FLAG_W-1:0] flag_w1c = wr_flags ? (w_data[`ATX_FLAG_W-1:0] & {4{w_strb[0]}}) : 4'h0;

   atx_pkg::atx_det_state_t det_state;
   logic [1:0]              db;
   wire [31:0] status_word = {27'h0000000, adc_stereo_mode, adc_voice_mode,
                              det_state == atx_pkg::ATX_DET_PRESSED,
                              det_state == atx_pkg::ATX_DET_HEADSET || det_state == atx_pkg::ATX_DET_PRESSED,
                              db[0]};

   wire        rd_ctrl   = s_axi_araddr == `ATX_OFF_CTRL;
   wire        rd_gain   = s_axi_araddr == `ATX_OFF_GAIN;
   wire        rd_flags  = s_axi_araddr == `ATX_OFF_FLAGS;
   wire        rd_mask   = s_axi_araddr == `ATX_OFF_MASK;
   wire        rd_status = s_axi_araddr == `ATX_OFF_STATUS;
   wire        rd_known  = rd_ctrl | rd_gain | rd_flags | rd_mask | rd_status;
   wire [31:0] rd_word   = rd_ctrl   ? ctrl_wide :
                           rd_gain   ? gain_wide :
                           rd_flags  ? {28'h0000000, flags} :
                           rd_mask   ? mask_wide :
                           rd_status ? status_word : 32'h00000000;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ATX_RESP_OKAY;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end else if (do_write) begin
            s_axi_awready <= 1'b1;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end else if (do_write) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `ATX_RESP_OKAY : `ATX_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `ATX_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_known ? `ATX_RESP_OKAY : `ATX_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `ATX_CTRL_RESET;
         gain <= {`ATX_FINE_RESET, `ATX_FINE_RESET, `ATX_ADC_GAIN_RESET, 2'b00,
                  `ATX_COARSE_RESET, `ATX_COARSE_RESET};
         mask <= `ATX_MASK_RESET;
      end else begin
         if (wr_ctrl) ctrl <= ctrl_new[`ATX_CTRL_W-1:0];
         if (wr_gain) gain <= gain_new[`ATX_GAIN_W-1:0];
         if (wr_mask) mask <= mask_new[`ATX_FLAG_W-1:0];
      end
   end

   // ---------------- pin synchronisers and debounce ----------------
   wire [3:0]  pins_raw = {second_pdm_mic, first_pdm_mic, acc_low_imp_raw, acc_present_raw};
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic [DBW-1:0] db_cnt [2];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= pins_raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire [3:0] pin_agree = ~(sync2 ^ sync3);

   for (genvar i = 0; i < 2; i++) begin : g_debounce
      wire moving = pin_agree[i] & (sync3[i] != db[i]);
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            db[i]     <= 1'b0;
            db_cnt[i] <= '0;
         end else if (!moving) begin
            db_cnt[i] <= '0;
         end else if (db_cnt[i] == DBW'(DEBOUNCE_CYCLES - 1)) begin
            db[i]     <= sync3[i];
            db_cnt[i] <= '0;
         end else begin
            db_cnt[i] <= db_cnt[i] + DBW'(1);
         end
      end
   end

   // ---------------- accessory detector ----------------
   logic           present_q;
   logic [LPW-1:0] push_cnt;
   wire  det_en    = ctrl[`ATX_CTRL_DET_EN];
   wire  full_mode = ctrl[`ATX_CTRL_AUDIO_BIAS] & ctrl[`ATX_CTRL_BIAS2];
   wire  attach    = db[0] & ~present_q;
   wire  detach    = ~db[0] & present_q;
   wire  low_imp   = db[1];
   wire  long_done = push_cnt == LPW'(LONG_PUSH_CYCLES);

   atx_pkg::atx_det_state_t next_det_state;
   logic [`ATX_FLAG_W-1:0]  ev_set;
   logic [`ATX_FLAG_W-1:0]  ev_clr;

   always_comb begin
      next_det_state = det_state;
      ev_set         = 4'h0;
      ev_clr         = 4'h0;
      if (!det_en) begin
         next_det_state = atx_pkg::ATX_DET_EMPTY;
      end else if (detach) begin
         next_det_state = atx_pkg::ATX_DET_EMPTY;
         if (!full_mode || det_state == atx_pkg::ATX_DET_HEADPHONE) begin
            ev_set[`ATX_FLAG_HP] = 1'b1;
         end
      end else begin
         unique case (det_state)
            atx_pkg::ATX_DET_EMPTY: begin
               if (attach) begin
                  if (full_mode && !low_imp) begin
                     next_det_state     = atx_pkg::ATX_DET_HEADSET;
                     ev_set[`ATX_FLAG_HS] = 1'b1;
                  end else begin
                     next_det_state     = atx_pkg::ATX_DET_HEADPHONE;
                     ev_set[`ATX_FLAG_HP] = 1'b1;
                  end
               end
            end
            atx_pkg::ATX_DET_HEADPHONE: begin
               if (full_mode && !low_imp) begin
                  next_det_state       = atx_pkg::ATX_DET_HEADSET;
                  ev_clr[`ATX_FLAG_HP] = 1'b1;
                  ev_set[`ATX_FLAG_HS] = 1'b1;
               end
            end
            atx_pkg::ATX_DET_HEADSET: begin
               if (full_mode && low_imp) begin
                  next_det_state = atx_pkg::ATX_DET_PRESSED;
               end
            end
            atx_pkg::ATX_DET_PRESSED: begin
               if (!low_imp) begin
                  next_det_state = atx_pkg::ATX_DET_HEADSET;
                  if (long_done) begin
                     ev_set[`ATX_FLAG_LONG] = 1'b1;
                  end else begin
                     ev_set[`ATX_FLAG_SHORT] = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   wire [`ATX_FLAG_W-1:0] next_flags = (flags & ~flag_w1c & ~ev_clr) | ev_set;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         det_state          <= atx_pkg::ATX_DET_EMPTY;
         present_q          <= 1'b0;
         push_cnt           <= '0;
         flags              <= 4'h0;
         host_interrupt_pin <= 1'b0;
      end else begin
         det_state          <= next_det_state;
         present_q          <= db[0];
         if (det_state != atx_pkg::ATX_DET_PRESSED) begin
            push_cnt <= '0;
         end else if (!long_done) begin
            push_cnt <= push_cnt + LPW'(1);
         end
         flags              <= next_flags;
         host_interrupt_pin <= |(next_flags & ~mask);
      end
   end

   // ---------------- adc mode and routing ----------------
   wire voice  = ctrl[`ATX_CTRL_VOICE_ADC];
   wire stereo = ctrl[`ATX_CTRL_STEREO_ADC] & ~voice;
   wire pdm1   = ctrl[`ATX_CTRL_PDM1_EN];
   wire pdm2   = ctrl[`ATX_CTRL_PDM2_EN];
   wire lamp   = ctrl[`ATX_CTRL_LAMP_EN];

   // left side and right side selection, pdm replaces the analog source
   wire atx_pkg::atx_src_t left_side  = pdm1 ? atx_pkg::ATX_SRC_FIRST_PDM  : atx_pkg::ATX_SRC_LEFT_ANA;
   wire atx_pkg::atx_src_t right_side = pdm2 ? atx_pkg::ATX_SRC_SECOND_PDM : atx_pkg::ATX_SRC_RIGHT_ANA;
   // first pin pdm cannot feed voice mode
   wire atx_pkg::atx_src_t voice_src  = !lamp ? right_side :
                                        pdm1  ? atx_pkg::ATX_SRC_NONE : left_side;
   wire atx_pkg::atx_src_t next_left  = voice  ? voice_src :
                                        stereo ? left_side : atx_pkg::ATX_SRC_NONE;
   wire atx_pkg::atx_src_t next_right = voice  ? voice_src :
                                        stereo ? right_side : atx_pkg::ATX_SRC_NONE;

   function automatic logic pdm_pick(input atx_pkg::atx_src_t src, input logic d1, input logic d2);
      pdm_pick = (src == atx_pkg::ATX_SRC_FIRST_PDM) ? d1 :
                 (src == atx_pkg::ATX_SRC_SECOND_PDM) ? d2 : 1'b0;
   endfunction : pdm_pick

   // ---------------- mic clock ----------------
   logic [MCW-1:0] mc_cnt;
   wire  [MCW-1:0] mc_half = ctrl[`ATX_CTRL_MCLK_RATE] ? MCW'(HALF_HI) : MCW'(HALF_LO);
   wire            mc_wrap = mc_cnt >= mc_half - MCW'(1);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mc_cnt           <= '0;
         mic_clock_output <= 1'b0;
      end else if (!ctrl[`ATX_CTRL_MCLK_EN]) begin
         mc_cnt           <= '0;
         mic_clock_output <= 1'b0;
      end else if (mc_wrap) begin
         mc_cnt           <= '0;
         mic_clock_output <= ~mic_clock_output;
      end else begin
         mc_cnt           <= mc_cnt + MCW'(1);
      end
   end

   // ---------------- registered outputs ----------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         first_bias_output    <= 1'b0;
         second_bias_output   <= 1'b0;
         first_bias_high      <= 1'b0;
         adc_voice_mode       <= 1'b0;
         adc_stereo_mode      <= 1'b0;
         left_mic_amp_enable  <= 1'b0;
         right_mic_amp_enable <= 1'b0;
         left_source_select   <= 1'b0;
         right_source_select  <= 1'b0;
         left_channel_src     <= atx_pkg::ATX_SRC_NONE;
         right_channel_src    <= atx_pkg::ATX_SRC_NONE;
         pdm_left_data        <= 1'b0;
         pdm_right_data       <= 1'b0;
         left_coarse_gain     <= `ATX_COARSE_RESET;
         right_coarse_gain    <= `ATX_COARSE_RESET;
         left_input_mute      <= 1'b0;
         right_input_mute     <= 1'b0;
         adc_transmit_gain    <= `ATX_ADC_GAIN_RESET;
         left_fine_volume     <= `ATX_FINE_RESET;
         right_fine_volume    <= `ATX_FINE_RESET;
      end else begin
         first_bias_output    <= ctrl[`ATX_CTRL_BIAS1];
         second_bias_output   <= ctrl[`ATX_CTRL_BIAS2];
         first_bias_high      <= ctrl[`ATX_CTRL_BIAS1] & ctrl[`ATX_CTRL_BOOST];
         adc_voice_mode       <= voice;
         adc_stereo_mode      <= stereo;
         left_mic_amp_enable  <= lamp;
         right_mic_amp_enable <= ctrl[`ATX_CTRL_RAMP_EN];
         left_source_select   <= ctrl[`ATX_CTRL_LSEL];
         right_source_select  <= ctrl[`ATX_CTRL_RSEL];
         left_channel_src     <= next_left;
         right_channel_src    <= next_right;
         pdm_left_data        <= pdm_pick(next_left, sync3[2], sync3[3]);
         pdm_right_data       <= pdm_pick(next_right, sync3[2], sync3[3]);
         left_coarse_gain     <= gain[`ATX_GAIN_LCOARSE_LSB +: 2];
         right_coarse_gain    <= gain[`ATX_GAIN_RCOARSE_LSB +: 2];
         left_input_mute      <= gain[`ATX_GAIN_LMUTE];
         right_input_mute     <= gain[`ATX_GAIN_RMUTE];
         adc_transmit_gain    <= gain[`ATX_GAIN_ADC_LSB +: 5];
         left_fine_volume     <= gain[`ATX_GAIN_LFINE_LSB +: 6];
         right_fine_volume    <= gain[`ATX_GAIN_RFINE_LSB +: 6];
      end
   end

endmodule : atx_top

`default_nettype wire

// ### include/atx_consts.svh
// constants of the transmit routing and accessory detect block
`ifndef ATX_CONSTS_SVH
`define ATX_CONSTS_SVH

`define ATX_ADDR_W         8
`define ATX_OFF_CTRL       8'h00
`define ATX_OFF_GAIN       8'h04
`define ATX_OFF_FLAGS      8'h08
`define ATX_OFF_MASK       8'h0C
`define ATX_OFF_STATUS     8'h10

`define ATX_CTRL_STEREO_ADC   0
`define ATX_CTRL_VOICE_ADC    1
`define ATX_CTRL_BIAS1        2
`define ATX_CTRL_BIAS2        3
`define ATX_CTRL_BOOST        4
`define ATX_CTRL_DET_EN       5
`define ATX_CTRL_AUDIO_BIAS   6
`define ATX_CTRL_LAMP_EN      7
`define ATX_CTRL_RAMP_EN      8
`define ATX_CTRL_LSEL         9
`define ATX_CTRL_RSEL         10
`define ATX_CTRL_MCLK_EN      11
`define ATX_CTRL_MCLK_RATE    12
`define ATX_CTRL_PDM1_EN      13
`define ATX_CTRL_PDM2_EN      14
`define ATX_CTRL_W            15

`define ATX_GAIN_LCOARSE_LSB  0
`define ATX_GAIN_RCOARSE_LSB  2
`define ATX_GAIN_LMUTE        4
`define ATX_GAIN_RMUTE        5
`define ATX_GAIN_ADC_LSB      6
`define ATX_GAIN_LFINE_LSB    11
`define ATX_GAIN_RFINE_LSB    17
`define ATX_GAIN_W            23

`define ATX_FLAG_HP           0
`define ATX_FLAG_HS           1
`define ATX_FLAG_SHORT        2
`define ATX_FLAG_LONG         3
`define ATX_FLAG_W            4

`define ATX_CTRL_RESET        15'h0000
`define ATX_FINE_RESET        6'h39
`define ATX_COARSE_RESET      2'h0
`define ATX_ADC_GAIN_RESET    5'h00
`define ATX_MASK_RESET        4'h0

`define ATX_CLK_HZ            100000000
`define ATX_MS_PER_S          1000
`define ATX_DEBOUNCE_MS       30
`define ATX_LONG_PUSH_S       2
`define ATX_MCLK_LO_HZ        1000000
`define ATX_MCLK_HI_HZ        2000000

`define ATX_RESP_OKAY         2'h0
`define ATX_RESP_SLVERR       2'h2

`endif

// ### include/atx_pkg.sv
// types of the transmit routing and accessory detect block
package atx_pkg;

   typedef enum logic [1:0] {
      ATX_DET_EMPTY     = 2'b00,
      ATX_DET_HEADPHONE = 2'b01,
      ATX_DET_HEADSET   = 2'b10,
      ATX_DET_PRESSED   = 2'b11
   } atx_det_state_t;

   typedef enum logic [2:0] {
      ATX_SRC_NONE      = 3'b000,
      ATX_SRC_LEFT_ANA  = 3'b001,
      ATX_SRC_RIGHT_ANA = 3'b010,
      ATX_SRC_FIRST_PDM = 3'b011,
      ATX_SRC_SECOND_PDM= 3'b100
   } atx_src_t;

endpackage : atx_pkg

// ### verification/atx_jack_model.sv
// behavioural jack accessory and pdm microphones
`timescale 1ns/1ps
`default_nettype none
module atx_jack_model (
   input  wire logic sys_clk,
   input  wire logic plugged,
   input  wire logic pressed,
   input  wire logic mic_clock_output,
   output logic      acc_present_raw,
   output logic      acc_low_imp_raw,
   output logic      first_pdm_mic,
   output logic      second_pdm_mic
);
   initial {acc_present_raw, acc_low_imp_raw, first_pdm_mic, second_pdm_mic} = 4'h0;
   always @(posedge sys_clk) begin
      acc_present_raw <= plugged;
      acc_low_imp_raw <= plugged & pressed;
   end
   // each mic launches a fresh bit on every mic clock edge
   always @(mic_clock_output) begin
      first_pdm_mic  <= 1'($urandom);
      second_pdm_mic <= 1'($urandom);
   end
endmodule : atx_jack_model
`default_nettype wire

// ### verification/atx_monitor.sv
// assertion checker on the transmit block ports
`timescale 1ns/1ps
`default_nettype none
module atx_monitor (
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic              adc_voice_mode,
   input wire logic              adc_stereo_mode,
   input wire logic              first_bias_output,
   input wire logic              first_bias_high,
   input wire logic              left_mic_amp_enable,
   input wire atx_pkg::atx_src_t left_channel_src,
   input wire atx_pkg::atx_src_t right_channel_src,
   input wire logic              pdm_left_data,
   input wire logic              pdm_right_data,
   input wire logic              mic_clock_output
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_adc_one_mode: assert property (!(adc_voice_mode && adc_stereo_mode))
      else $error("both adc modes");
   a_boost_first: assert property (first_bias_high |-> first_bias_output)
      else $error("boost without bias");
   a_stereo_left: assert property (adc_stereo_mode |-> left_channel_src != atx_pkg::ATX_SRC_RIGHT_ANA)
      else $error("right source on left");
   a_stereo_right: assert property (adc_stereo_mode |-> right_channel_src != atx_pkg::ATX_SRC_LEFT_ANA)
      else $error("left source on right");
   a_voice_both: assert property (adc_voice_mode |-> left_channel_src == right_channel_src
      && left_channel_src != atx_pkg::ATX_SRC_FIRST_PDM) else $error("voice channels differ");
   a_voice_left: assert property (adc_voice_mode && left_mic_amp_enable
      |-> left_channel_src != atx_pkg::ATX_SRC_RIGHT_ANA) else $error("voice took right side");
   a_pdm_direct: assert property (pdm_left_data |-> left_channel_src inside {atx_pkg::ATX_SRC_FIRST_PDM,
      atx_pkg::ATX_SRC_SECOND_PDM} || $past(left_channel_src) inside {atx_pkg::ATX_SRC_FIRST_PDM,
      atx_pkg::ATX_SRC_SECOND_PDM}) else $error("pdm bit on analog route");
   a_pdm_right: assert property (pdm_right_data |-> right_channel_src inside {atx_pkg::ATX_SRC_FIRST_PDM,
      atx_pkg::ATX_SRC_SECOND_PDM}) else $error("pdm bit on analog right route");
   // low phase: disabling the clock only lengthens it
   a_mclk_half: assert property ($fell(mic_clock_output) |=> (!mic_clock_output) [*8])
      else $error("mic clock low too short");
   c_voice: cover property (adc_voice_mode);
   c_stereo: cover property (adc_stereo_mode);
   c_mclk: cover property ($rose(mic_clock_output));
endmodule : atx_monitor

bind atx_top atx_monitor i_atx_monitor (.sys_clk, .resetn, .adc_voice_mode, .adc_stereo_mode, .first_bias_output,
   .first_bias_high, .left_mic_amp_enable, .left_channel_src, .right_channel_src, .pdm_left_data, .pdm_right_data,
   .mic_clock_output);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the transmit routing block
`timescale 1ns/1ps
`include "atx_consts.svh"
`default_nettype none
module tb_top;
   logic        sys_clk = 1'b0, resetn = 1'b0, plugged = 1'b0, pressed = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, ctrl, g;
   logic [3:0]  s_axi_wstrb = 4'hF, mk;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rp, left_coarse_gain, right_coarse_gain;
   logic        acc_present_raw, acc_low_imp_raw, first_pdm_mic, second_pdm_mic, host_interrupt_pin;
   logic        first_bias_output, second_bias_output, first_bias_high, adc_voice_mode, adc_stereo_mode;
   logic        left_mic_amp_enable, right_mic_amp_enable, left_source_select, right_source_select;
   logic        left_input_mute, right_input_mute, mic_clock_output;
   logic [4:0]  adc_transmit_gain;
   logic [5:0]  left_fine_volume, right_fine_volume;
   atx_pkg::atx_src_t left_channel_src, right_channel_src;
   int          n_fail = 0, checks = 0;

   atx_top #(.DEBOUNCE_CYCLES(8), .LONG_PUSH_CYCLES(40)) i_atx_top (.sys_clk, .resetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .acc_present_raw, .acc_low_imp_raw, .first_pdm_mic, .second_pdm_mic,
      .host_interrupt_pin, .first_bias_output, .second_bias_output, .first_bias_high, .adc_voice_mode,
      .adc_stereo_mode, .left_mic_amp_enable, .right_mic_amp_enable, .left_source_select, .right_source_select,
      .left_channel_src, .right_channel_src, .pdm_left_data(), .pdm_right_data(), .left_coarse_gain,
      .right_coarse_gain, .left_input_mute, .right_input_mute, .adc_transmit_gain, .left_fine_volume,
      .right_fine_volume, .mic_clock_output);
   atx_jack_model i_atx_jack_model (.sys_clk, .plugged, .pressed, .mic_clock_output, .acc_present_raw,
      .acc_low_imp_raw, .first_pdm_mic, .second_pdm_mic);

   always #5 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            rp = s_axi_bresp;
         end
      end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            rv = s_axi_rdata;
            rp = s_axi_rresp;
         end
      end while (s_axi_arvalid | s_axi_rready);
   endtask : rd
   // expected {left, right} channel sources
   function automatic logic [5:0] route(input logic [31:0] c);
      logic [2:0] l, r;
      l = c[13] ? 3'h3 : 3'h1;
      r = c[14] ? 3'h4 : 3'h2;
      if (c[1]) begin
         l = c[7] ? (c[13] ? 3'h0 : l) : r;
         r = l;
      end else if (!c[0]) begin
         l = 3'h0;
         r = 3'h0;
      end
      return {l, r};
   endfunction : route
   task automatic acc(input logic p, input logic l, input int n, input logic [3:0] e);
      plugged <= p;
      pressed <= l;
      repeat (n) @(posedge sys_clk);
      rd(`ATX_OFF_FLAGS);
      chk(rv, e);
      chk(host_interrupt_pin, |(e & ~mk));
   endtask : acc

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      test_done();
   end
   initial begin
      void'($urandom(32'h9720));
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(mic_clock_output, 0);
      rd(`ATX_OFF_GAIN);
      chk(rv, (32'h39 << 17) | (32'h39 << 11));
      rd(8'h14);
      chk(rv, 32'h00000000);
      chk(rp, `ATX_RESP_SLVERR);
      wr(8'h14, 32'hFFFFFFFF);
      chk(rp, `ATX_RESP_SLVERR);
      for (int i = 0; i < 24; i++) begin
         ctrl = ($urandom & 32'h77FF) | 32'h0800;
         g = $urandom & 32'h7FFFFF;
         wr(`ATX_OFF_CTRL, ctrl);
         wr(`ATX_OFF_GAIN, g);
         rd(`ATX_OFF_CTRL);
         chk(rv, ctrl);
         chk({adc_voice_mode, adc_stereo_mode}, {ctrl[1], ctrl[0] & ~ctrl[1]});
         chk({first_bias_output, second_bias_output, first_bias_high},
            {ctrl[2], ctrl[3], ctrl[2] & ctrl[4]});
         chk({right_source_select, left_source_select, right_mic_amp_enable, left_mic_amp_enable},
            ctrl[10:7]);
         chk({right_fine_volume, left_fine_volume, adc_transmit_gain, right_input_mute, left_input_mute,
            right_coarse_gain, left_coarse_gain}, g);
         chk({left_channel_src, right_channel_src}, route(ctrl));
      end
      mk = 4'h0;
      wr(`ATX_OFF_CTRL, 32'h20);
      wr(`ATX_OFF_FLAGS, 32'hF);
      acc(1'b1, 1'b0, 30, 4'h1);
      mk = 4'h1;
      wr(`ATX_OFF_MASK, 32'h1);
      acc(1'b1, 1'b0, 2, 4'h1);
      wr(`ATX_OFF_CTRL, 32'h68);
      acc(1'b1, 1'b0, 30, 4'h2);
      for (int k = 0; k < 2; k++) begin
         wr(`ATX_OFF_FLAGS, 32'hF);
         acc(1'b1, 1'b1, k ? 70 : 20, 4'h0);
         acc(1'b1, 1'b0, 30, k ? 4'h8 : 4'h4);
      end
      wr(`ATX_OFF_FLAGS, 32'hF);
      acc(1'b0, 1'b0, 30, 4'h0);
      acc(1'b1, 1'b1, 30, 4'h1);
      acc(1'b1, 1'b0, 30, 4'h2);
      mk = 4'h2;
      wr(`ATX_OFF_MASK, 32'h2);
      acc(1'b1, 1'b0, 2, 4'h2);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
